// >>> src/rssig_top.v
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rssig_map.vh"

// octet fifo with a registered read stage so the drain side sees flop outputs
// capacity is the memory depth plus the one word held in the read stage
// full is judged on the next count so a push into the last free slot is safe
module rssig_fifo #(
	parameter W = 8,
	parameter D = 16,
	parameter AW = 4
) (
	input wire core_clk,
	input wire nrst,
	input wire wr_valid,
	output reg wr_ready,
	input wire [W-1:0] wr_data,
	output reg rd_valid,
	input wire rd_ready,
	output reg [W-1:0] rd_data
);
	// memory plus read stage hold D + 1 words in all
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;
	wire [AW:0] next_cnt;

	// a push and a pop in one cycle leave the count where it was
	// pop only when the output stage is empty or being drained
	assign push = wr_valid && wr_ready;
	assign pop = (cnt != {(AW+1){1'b0}}) && (!rd_valid || rd_ready);
	assign next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// pointers, count and flags
	// the read stage refills whenever memory holds a word and the stage is empty or being taken
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
			wr_ready <= 1'b1;
			rd_valid <= 1'b0;
			rd_data <= {W{1'b0}};
		end
		else
		begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
			begin
				rp <= rp + 1'b1;
				rd_data <= mem[rp];
				rd_valid <= 1'b1;
			end
			else if (rd_ready)
				rd_valid <= 1'b0;
			cnt <= next_cnt;
			// full is registered so the source sees it without a comb path
			wr_ready <= (next_cnt != D[AW:0]);
		end
	end

	// storage needs no reset
	// words are only read after they were written, so no unknown leaves
	always @(posedge core_clk)
	begin
		if (push)
			mem[wp] <= wr_data;
	end
endmodule // rssig_fifo

module rssig_top #(
	parameter NTS = 24,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire core_clk,
	input wire nrst,
	input wire [15:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg wb_ack_o,
	input wire rx_valid,
	output wire rx_ready,
	input wire [4:0] rx_ts,
	input wire [7:0] rx_octet,
	input wire rx_rb_frame,
	input wire [1:0] rx_rb_bit,
	input wire rx_sf_end,
	output wire pcm_valid,
	input wire pcm_ready,
	output wire [7:0] pcm_octet,
	output reg sig_valid,
	output reg [4:0] sig_ts,
	output reg [3:0] sig_abcd,
	output reg oh_valid,
	output reg [4:0] oh_ts,
	output reg [3:0] oh_abcd
);
	// per-slot banks; array, current and previous state are hardware owned
	// cur collects robbed bits as they arrive, prev holds the last superframe
	reg [7:0] ctl [0:NTS-1];
	reg [3:0] subv [0:NTS-1];
	reg [3:0] sarr [0:NTS-1];
	reg [3:0] cur [0:NTS-1];
	reg [3:0] prev [0:NTS-1];
	reg [7:0] gcfg;
	integer i;
	integer j;

	// word index decode: returns {hit, slot} for a 24-entry bank at base
	// below base the subtraction wraps high, so one compare bounds both ends
	function [5:0] bank_hit;
		input [13:0] idx;
		input [11:0] base;
		reg [13:0] off;
		begin
			off = idx - {2'b00, base};
			bank_hit = {(off < {9'h000, `RSSIG_NUM_TS}), off[4:0]};
		end
	endfunction

	// one bit of {a,b,c,d} positions, bit a at the top
	// the same mask gates the array write and zeroes the bits not extracted
	function [3:0] ext_mask;
		input [1:0] ext;
		begin
			case (ext)
				`RSSIG_EXT_16: ext_mask = `RSSIG_MASK_16;
				`RSSIG_EXT_4: ext_mask = `RSSIG_MASK_4;
				`RSSIG_EXT_2: ext_mask = `RSSIG_MASK_2;
				default: ext_mask = `RSSIG_MASK_0;
			endcase
		end
	endfunction

	// bus side
	// a write lands at the edge that takes it; ack follows one cycle later
	// with ack still high the master's old cycle is not taken a second time
	wire [13:0] widx;
	wire [5:0] hit_ctl;
	wire [5:0] hit_subv;
	wire [5:0] hit_arr;
	wire hit_gcfg;
	wire wb_req;
	wire wb_wr;
	reg [31:0] next_rdata;

	assign widx = wb_adr_i[15:2];
	assign hit_ctl = bank_hit(widx, `RSSIG_IDX_CTL);
	assign hit_subv = bank_hit(widx, `RSSIG_IDX_SUBV);
	assign hit_arr = bank_hit(widx, `RSSIG_IDX_ARR);
	assign hit_gcfg = (widx == {2'b00, `RSSIG_IDX_GCFG});
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// only the low byte lane carries register data
	// a write with that lane off still gets its ack
	assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

	// read mux; unmapped words read zero
	// the banks never overlap, so the priority order changes nothing
	always @*
	begin
		next_rdata = 32'h0000_0000;
		if (hit_ctl[5])
			next_rdata = {24'h00_0000, ctl[hit_ctl[4:0]]};
		else if (hit_subv[5])
			next_rdata = {28'h000_0000, subv[hit_subv[4:0]]};
		else if (hit_arr[5])
			next_rdata = {28'h000_0000, sarr[hit_arr[4:0]]};
		else if (hit_gcfg)
			next_rdata = {24'h00_0000, gcfg};
	end

	// classic slave: ack one cycle after the request, dropped the cycle after
	// read data loads only on reads, so it stands until the next read
	// control and substitution banks start cleared: nothing extracted or replaced
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			gcfg <= `RSSIG_RST_GCFG;
			for (i = 0; i < NTS; i = i + 1)
			begin
				ctl[i] <= `RSSIG_RST_CTL;
				subv[i] <= `RSSIG_RST_SUBV;
			end
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i)
				wb_dat_o <= next_rdata;
			// register writes take the low byte only
			if (wb_wr && hit_ctl[5])
				ctl[hit_ctl[4:0]] <= wb_dat_i[7:0];
			if (wb_wr && hit_subv[5])
				subv[hit_subv[4:0]] <= wb_dat_i[3:0];
			if (wb_wr && hit_gcfg)
				gcfg <= wb_dat_i[7:0];
		end
	end

	// stream side: decode the accepted octet's slot
	// slots above the last pass through untouched and never index a bank
	// the robbed bit always rides in bit 0 of the octet
	wire acc;
	wire ts_ok;
	wire [7:0] tctl;
	wire [3:0] tsub;
	wire [3:0] tsarr;
	wire [3:0] tprev;
	wire [3:0] emask;
	wire [3:0] bitpos;
	wire [1:0] fmt;
	wire rxbit;
	reg sub_bit;
	reg [3:0] next_cur;
	reg [3:0] next_arr;
	reg arr_wr;
	wire [7:0] sub_octet;

	// per-octet views of the addressed slot's registers
	assign acc = rx_valid && rx_ready;
	assign ts_ok = (rx_ts < `RSSIG_NUM_TS);
	assign tctl = ts_ok ? ctl[rx_ts] : `RSSIG_RST_CTL;
	assign tsub = ts_ok ? subv[rx_ts] : `RSSIG_RST_SUBV;
	assign tsarr = ts_ok ? sarr[rx_ts] : `RSSIG_RST_SUBV;
	assign tprev = ts_ok ? prev[rx_ts] : `RSSIG_RST_SUBV;
	assign emask = ext_mask(tctl[`RSSIG_EXT_HI:`RSSIG_EXT_LO]);
	assign fmt = tctl[`RSSIG_FMT_HI:`RSSIG_FMT_LO];
	assign bitpos = `RSSIG_MASK_2 >> rx_rb_bit; // a..d onto bits 3..0
	assign rxbit = rx_octet[0];

	// substituted robbed bit; bits outside the format pass through
	// the substitution value only ever reaches the pcm copy of the octet
	always @*
	begin
		case (fmt)
			`RSSIG_FMT_ONES: sub_bit = 1'b1;
			`RSSIG_FMT_16: sub_bit = |(tsub & bitpos);
			`RSSIG_FMT_4: sub_bit = (bitpos & `RSSIG_MASK_4) != 4'h0 ? |(tsub & bitpos) : rxbit;
			`RSSIG_FMT_2: sub_bit = (bitpos == `RSSIG_MASK_2) ? tsub[3] : rxbit;
			default: sub_bit = rxbit;
		endcase
	end

	// pcm path only sees the substitution; the array uses rxbit
	// octets without a robbed bit are never altered
	assign sub_octet = (ts_ok && rx_rb_frame && tctl[`RSSIG_SUB_EN]) ?
		{rx_octet[7:1], sub_bit} : rx_octet;

	// extracted state and the decision to write the array
	// debounce compares the finished superframe with the one before it
	// the frame-boundary option is moot under debounce, which already waits
	// only a changed value writes the array, so the pin pulses only on change
	always @*
	begin
		next_cur = ts_ok ? cur[rx_ts] : 4'h0;
		if (rx_rb_frame)
			next_cur = ((next_cur & ~bitpos) | (rxbit ? bitpos : 4'h0)) & emask;
		next_arr = next_cur;
		arr_wr = 1'b0;
		if (emask != `RSSIG_MASK_0)
		begin
			if (tctl[`RSSIG_DEB_EN])
				arr_wr = rx_sf_end && (next_cur == tprev);
			else if (gcfg[`RSSIG_GCFG_SFB])
				arr_wr = rx_sf_end;
			else
				arr_wr = rx_rb_frame;
		end
		arr_wr = arr_wr && ts_ok && acc && (next_arr != tsarr);
	end

	// per-slot state, signaling pin and overhead pin
	// overhead pulses on every accepted octet of an enabled slot
	// pin and overhead outputs keep their last slot and value between pulses
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			// all slot state clears so no stale superframe can pass debounce
			for (j = 0; j < NTS; j = j + 1)
			begin
				sarr[j] <= `RSSIG_RST_SUBV;
				cur[j] <= `RSSIG_RST_SUBV;
				prev[j] <= `RSSIG_RST_SUBV;
			end
			sig_valid <= 1'b0;
			sig_ts <= 5'h00;
			sig_abcd <= 4'h0;
			oh_valid <= 1'b0;
			oh_ts <= 5'h00;
			oh_abcd <= 4'h0;
		end
		else
		begin
			sig_valid <= 1'b0;
			oh_valid <= 1'b0;
			if (acc && ts_ok)
			begin
				cur[rx_ts] <= next_cur;
				if (rx_sf_end)
					prev[rx_ts] <= next_cur; // last superframe for the two-in-a-row check
				if (arr_wr)
					sarr[rx_ts] <= next_arr;
				// pin only moves with the array, so debounce governs both
				// the pin interface is off after reset until software enables it
				if (arr_wr && gcfg[`RSSIG_GCFG_SIGIF])
				begin
					sig_valid <= 1'b1;
					sig_ts <= rx_ts;
					sig_abcd <= next_arr;
				end
				if (tctl[`RSSIG_OH_EN])
				begin
					oh_valid <= 1'b1;
					oh_ts <= rx_ts;
					oh_abcd <= arr_wr ? next_arr : tsarr;
				end
			end
		end
	end

	// pcm toward the backplane; a stalled drain backs up to rx_ready
	// every offered octet enters, out-of-range slots included
	// the drain sets the pace; no octet is ever dropped
	rssig_fifo #(
		.W(8),
		.D(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr_valid(rx_valid),
		.wr_ready(rx_ready),
		.wr_data(sub_octet),
		.rd_valid(pcm_valid),
		.rd_ready(pcm_ready),
		.rd_data(pcm_octet)
	);
endmodule // rssig_top
`default_nettype wire

// >>> src/rssig_map.vh
`ifndef RSSIG_MAP_VH
`define RSSIG_MAP_VH
// register indices; byte address is four times the index
`define RSSIG_IDX_CTL 12'h3a0
`define RSSIG_IDX_SUBV 12'h3c0
`define RSSIG_IDX_ARR 12'h500
`define RSSIG_IDX_GCFG 12'h107
`define RSSIG_NUM_TS 5'd24
// control register fields
`define RSSIG_SUB_EN 6
`define RSSIG_OH_EN 5
`define RSSIG_DEB_EN 4
`define RSSIG_FMT_HI 3
`define RSSIG_FMT_LO 2
`define RSSIG_EXT_HI 1
`define RSSIG_EXT_LO 0
// global config fields
`define RSSIG_GCFG_SFB 7
`define RSSIG_GCFG_SIGIF 0
// field encodings
`define RSSIG_FMT_ONES 2'h0
`define RSSIG_FMT_16 2'h1
`define RSSIG_FMT_4 2'h2
`define RSSIG_FMT_2 2'h3
`define RSSIG_EXT_NONE 2'h0
`define RSSIG_EXT_16 2'h1
`define RSSIG_EXT_4 2'h2
`define RSSIG_EXT_2 2'h3
// extraction masks over {a,b,c,d}
`define RSSIG_MASK_16 4'hf
`define RSSIG_MASK_4 4'hc
`define RSSIG_MASK_2 4'h8
`define RSSIG_MASK_0 4'h0
// reset values
`define RSSIG_RST_CTL 8'h00
`define RSSIG_RST_SUBV 4'h0
`define RSSIG_RST_GCFG 8'h00
`endif

// >>> verification/rssig_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// sees only top ports; ties bus and stream outputs to their causes
module rssig_monitor (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [4:0] rx_ts,
	input wire logic pcm_valid,
	input wire logic pcm_ready,
	input wire logic [7:0] pcm_octet,
	input wire logic sig_valid,
	input wire logic [4:0] sig_ts,
	input wire logic oh_valid,
	input wire logic [4:0] oh_ts
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_pcm_hold; pcm_valid && !pcm_ready |=> pcm_valid && $stable(pcm_octet); endproperty
	a_pcm_hold: assert property (p_pcm_hold) else $error("pcm dropped");
	property p_oh_cause; oh_valid |-> $past(rx_valid && rx_ready); endproperty
	a_oh_cause: assert property (p_oh_cause) else $error("overhead unasked");
	property p_oh_ts; oh_valid |-> oh_ts == $past(rx_ts); endproperty
	a_oh_ts: assert property (p_oh_ts) else $error("overhead slot");
	property p_oh_range; oh_valid |-> oh_ts < 5'd24; endproperty
	a_oh_range: assert property (p_oh_range) else $error("overhead range");
	property p_sig_cause; sig_valid |-> $past(rx_valid && rx_ready); endproperty
	a_sig_cause: assert property (p_sig_cause) else $error("signaling unasked");
	property p_sig_ts; sig_valid |-> sig_ts == $past(rx_ts); endproperty
	a_sig_ts: assert property (p_sig_ts) else $error("signaling slot");
	c_stall: cover property (pcm_valid && !pcm_ready);
	c_sig: cover property (sig_valid);
	c_oh: cover property (oh_valid);
endmodule // rssig_monitor
bind rssig_top rssig_monitor u_rssig_monitor (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid,
	.rx_ready, .rx_ts, .pcm_valid, .pcm_ready, .pcm_octet, .sig_valid, .sig_ts, .oh_valid, .oh_ts);
`default_nettype wire

// >>> verification/rssig_drain.sv
`timescale 1ns/1ps
`default_nettype none
// backplane sink; skips every third cycle so the output register must hold
module rssig_drain (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic stall,
	output logic pcm_ready
);
	logic [1:0] n;
	// stall models a backplane that stops taking data
	always @(posedge core_clk)
	begin
		n <= (!nrst || n == 2'h2) ? 2'h0 : n + 2'h1;
		pcm_ready <= nrst && !stall && n != 2'h2;
	end
endmodule // rssig_drain
`default_nettype wire

// >>> verification/test_rssig_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_rssig_top;
	logic core_clk = 1'b0;
	logic nrst, wb_we_i, wb_cyc_i, wb_stb_i, rx_valid, rx_rb_frame, rx_sf_end, stall;
	logic [15:0] wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [3:0] wb_sel_i, s, r, ec, ea;
	logic [4:0] rx_ts;
	logic [7:0] rx_octet, o;
	logic [1:0] rx_rb_bit;
	wire logic [31:0] wb_dat_o;
	wire logic wb_ack_o, rx_ready, pcm_valid, pcm_ready, sig_valid, oh_valid;
	wire logic [7:0] pcm_octet;
	wire logic [4:0] sig_ts, oh_ts;
	wire logic [3:0] sig_abcd, oh_abcd;
	logic [3:0] mk [4] = '{4'h0, 4'hf, 4'hc, 4'h8};
	logic [31:0] rq [$], pq [$], sq [$], hq [$];
	int num_errors, comparisons;
	rssig_top u_rssig_top (.core_clk, .nrst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
		.wb_stb_i, .wb_ack_o, .rx_valid, .rx_ready, .rx_ts, .rx_octet, .rx_rb_frame, .rx_rb_bit, .rx_sf_end,
		.pcm_valid, .pcm_ready, .pcm_octet, .sig_valid, .sig_ts, .sig_abcd, .oh_valid, .oh_ts, .oh_abcd);
	rssig_drain u_rssig_drain (.core_clk, .nrst, .stall, .pcm_ready);
	task chk(input [31:0] a, input [31:0] b);
		comparisons++;
		if (a !== b)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, a, b);
		end
	endtask
	task wrap_up;
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one classic bus cycle; a read notes its expected word
	task wb(input w, input [15:0] a, input [7:0] d, input [31:0] x);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= 4'hf;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		if (!w)
			rq.push_back(x);
		@(posedge core_clk);
		while (!wb_ack_o)
			@(posedge core_clk);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	// valid stays up after a send so bursts run back to back
	task send(input [4:0] t, input [7:0] v, input f, input [1:0] b, input e, input [7:0] x);
		rx_ts <= t;
		rx_octet <= v;
		rx_rb_frame <= f;
		rx_rb_bit <= b;
		rx_sf_end <= e;
		rx_valid <= 1'b1;
		pq.push_back({24'h0, x});
		@(posedge core_clk);
		while (!rx_ready)
			@(posedge core_clk);
	endtask
	task idle;
		rx_valid <= 1'b0;
		@(posedge core_clk);
	endtask
	// one superframe on slot five, A first, boundary flag with D
	task sf(input [3:0] v);
		for (int b = 0; b < 4; b++)
		begin
			o = $urandom;
			o[0] = v[3 - b];
			send(5'd5, o, 1'b1, 2'(b), b == 3, o);
		end
		idle;
	endtask
	function logic [7:0] ep(input [7:0] v, input [1:0] b, input [1:0] k, input [3:0] sv);
		ep = v;
		if (k == 2'h0)
			ep[0] = 1'b1;
		else if (k == 2'h1 || b == 2'h0 || (k == 2'h2 && b == 2'h1))
			ep[0] = sv[2'h3 - b];
	endfunction
	// each result is compared with the oldest note as it appears
	always @(posedge core_clk)
	begin
		if (wb_ack_o && !wb_we_i)
			chk(wb_dat_o, rq.pop_front());
		if (pcm_valid && pcm_ready)
			chk({24'h0, pcm_octet}, pq.pop_front());
		if (sig_valid)
			chk({23'h0, sig_ts, sig_abcd}, sq.pop_front());
		if (oh_valid)
			chk({23'h0, oh_ts, oh_abcd}, hq.pop_front());
	end
	initial
		forever #20 core_clk = ~core_clk;
	// the work takes about two hundred cycles
	initial
	begin
		#800000;
		num_errors++;
		wrap_up;
	end
	initial
	begin
		{nrst, wb_we_i, wb_cyc_i, wb_stb_i, rx_valid, rx_rb_frame, rx_sf_end, stall} = 8'h0;
		{wb_adr_i, wb_dat_i, wb_sel_i, rx_ts, rx_octet, rx_rb_bit, ec, ea} = '0;
		void'($urandom(13));
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		wb(1'b0, 16'he84, 8'h0, 32'h0);
		wb(1'b0, 16'h0, 8'h0, 32'h0);
		wb(1'b1, 16'h41c, 8'h01, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			s = $urandom;
			r = $urandom;
			wb(1'b1, 16'he8c, 8'h60 | 8'(k * 5), 32'h0);
			wb(1'b1, 16'hf0c, {4'h0, s}, 32'h0);
			for (int b = 0; b < 4; b++)
			begin
				o = $urandom;
				o[0] = r[3 - b];
				ec[3 - b] = r[3 - b];
				ec = ec & mk[k];
				if (k > 0 && ec != ea)
				begin
					ea = ec;
					sq.push_back({23'h0, 5'd3, ea});
				end
				hq.push_back({23'h0, 5'd3, ea});
				send(5'd3, o, 1'b1, 2'(b), 1'b0, ep(o, 2'(b), 2'(k), s));
			end
			hq.push_back({23'h0, 5'd3, ea});
			send(5'd3, o, 1'b0, 2'h0, 1'b0, o);
			idle;
			wb(1'b0, 16'h140c, 8'h0, {28'h0, r & mk[k]});
		end
		wb(1'b0, 16'he90, 8'h0, 32'h0);
		wb(1'b1, 16'he94, 8'h11, 32'h0);
		sf(4'ha);
		sq.push_back(32'h0000_005a);
		sf(4'ha);
		wb(1'b0, 16'h1414, 8'h0, 32'ha);
		sf(4'h5);
		wb(1'b0, 16'h1414, 8'h0, 32'ha);
		sq.push_back(32'h0000_0055);
		sf(4'h5);
		wb(1'b0, 16'h1414, 8'h0, 32'h5);
		wb(1'b1, 16'h41c, 8'h81, 32'h0);
		wb(1'b1, 16'he94, 8'h01, 32'h0);
		send(5'd5, 8'h01, 1'b1, 2'h0, 1'b0, 8'h01);
		idle;
		wb(1'b0, 16'h1414, 8'h0, 32'h5);
		stall <= 1'b1;
		repeat (17)
		begin
			o = $urandom;
			send(5'd9, o, 1'b0, 2'h0, 1'b0, o);
		end
		idle;
		@(posedge core_clk);
		chk({31'h0, rx_ready}, 32'h0);
		stall <= 1'b0;
		repeat (60) @(posedge core_clk);
		chk(pq.size() + sq.size() + hq.size(), 0);
		wrap_up;
	end
endmodule // test_rssig_top
`default_nettype wire
